// [verilog/fault_status_cfg.svh]
// status byte command codes and reset values
// included by the status bank, not by its leaf modules
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_VOUT_STATUS 8'h7A
`define CMD_IOUT_STATUS 8'h7B
`define CMD_INPUT_STATUS 8'h7C
`define CMD_THERM_STATUS 8'h7D
`define CMD_CML_STATUS 8'h7E
`define STATUS_RESET 8'h00
`define WORD_RESET 16'h0000
`define ZERO_BYTE 8'h00
`endif

// [verilog/fault_status_pkg.sv]
// types shared by the status bank files
// expects fault_status_cfg.svh for numeric constants
package fault_status_pkg;
   typedef struct packed {
      logic vout_ov;
      logic vout_uv;
      logic vout_range;
      logic vout_other;
      logic iout_oc;
      logic iout_oc_uv;
      logic iout_warn;
      logic vin_ov_warn;
      logic vin_uv_warn;
      logic ot_fault;
      logic ot_warn;
      logic bad_cmd;
      logic bad_data;
      logic mem_fault;
      logic cml_other;
      logic mem_busy;
      logic part_off;
      logic vin_fault;
      logic pgood_n;
      logic word_other;
   } detect_s;

   typedef struct packed {
      logic [7:0] cmd;
      logic rd;
   } read_req_s;
endpackage

// [verilog/sync2.sv]
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module sync2
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // pin and synchronised level
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
   } sync_s;
   sync_s q, d;
   always_comb begin
      d.s1 = din;
      d.s2 = q.s1;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign dout = q.s2;
endmodule // sync2

// [verilog/sticky_flag.sv]
// latched status flag: sets on cause, clears on clear command once gone
// assumes cause and clear come from mclk logic
`timescale 1ns/1ps
module sticky_flag
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // cause, clear and flag
   input wire logic cause,
   input wire logic clear,
   output logic flag
);
   logic flag_q, flag_d;
   always_comb begin
      flag_d = flag_q;
      if (cause) begin
         flag_d = 1'b1;
      end else if (clear) begin
         flag_d = 1'b0;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
   assign flag = flag_q;

   property p_set_wins;
      @(posedge mclk) disable iff (!resetn)
      cause |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag not set after cause");
endmodule // sticky_flag

// [verilog/fault_status_bank.sv]
// power converter fault status register bank, read by command code
// assumes detectors run on mclk, ov sense pin is asynchronous
// How it works
// - word bit 8 latches on fault not covered by other word bits
// - word bits 10 and 9 read zero; low byte equals summary byte
// - code 7A returns output voltage byte; bits 6,5,2,1 read zero
// - output voltage bit 7 follows live over-voltage fault
// - output voltage bit 4 follows live under-voltage fault
// - output voltage bit 3 shows out-of-range voltage programming attempt
// - output voltage bit 0 latches on unclassified fault
// - input byte bit 7 latches from over-voltage sense pin
// - input byte bit 6 latches on supply over-voltage warning
// - input byte bit 5 latches on supply under-voltage warning
// - input byte bits 4 to 0 read zero
// - latched flags hold until cause gone and clear command issued
// - temperature byte bit 7 latches on over-temperature fault
// - temperature bit 6 latches on warning; bits 5 to 0 zero
// - comm byte reports command, data, memory, other faults and busy
// - summary byte readable; latched bits clear only after removal
`timescale 1ns/1ps
`include "fault_status_cfg.svh"
module fault_status_bank
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // detector levels
   input detect_s det,
   input wire logic input_overvoltage_sense_pin,
   // clear faults command pulse
   input wire logic clear_faults,
   // read request
   input read_req_s req,
   // read answer
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic rd_unsup
);
   typedef struct packed {
      logic [15:0] data;
      logic valid;
      logic unsup;
   } bank_s;

   bank_s q, d;
   logic ov_pin_s;
   logic vin_ov_l, vin_ovw_l, vin_uvw_l;
   logic ot_f_l, ot_w_l;
   logic word_oth_l, vout_oth_l, iout_oc_l, cml_l;
   logic [7:0] vout_b, iout_b, input_b, therm_b, cml_b, sum_b;
   logic [15:0] word_w;

   sync2 u_ov_sync (
      .mclk(mclk),
      .resetn(resetn),
      .din(input_overvoltage_sense_pin),
      .dout(ov_pin_s)
   );

   // latched flags: clear only while cause is absent
   sticky_flag u_vin_ov (.mclk(mclk), .resetn(resetn),
      .cause(ov_pin_s), .clear(clear_faults), .flag(vin_ov_l));
   sticky_flag u_vin_ovw (.mclk(mclk), .resetn(resetn),
      .cause(det.vin_ov_warn), .clear(clear_faults), .flag(vin_ovw_l));
   sticky_flag u_vin_uvw (.mclk(mclk), .resetn(resetn),
      .cause(det.vin_uv_warn), .clear(clear_faults), .flag(vin_uvw_l));
   sticky_flag u_ot_f (.mclk(mclk), .resetn(resetn),
      .cause(det.ot_fault), .clear(clear_faults), .flag(ot_f_l));
   sticky_flag u_ot_w (.mclk(mclk), .resetn(resetn),
      .cause(det.ot_warn), .clear(clear_faults), .flag(ot_w_l));
   sticky_flag u_word_oth (.mclk(mclk), .resetn(resetn),
      .cause(det.word_other), .clear(clear_faults), .flag(word_oth_l));
   sticky_flag u_vout_oth (.mclk(mclk), .resetn(resetn),
      .cause(det.vout_other), .clear(clear_faults), .flag(vout_oth_l));
   sticky_flag u_iout_oc (.mclk(mclk), .resetn(resetn),
      .cause(det.iout_oc), .clear(clear_faults), .flag(iout_oc_l));
   sticky_flag u_cml (.mclk(mclk), .resetn(resetn),
      .cause(det.bad_cmd | det.bad_data | det.mem_fault | det.cml_other),
      .clear(clear_faults), .flag(cml_l));

   always_comb begin
      vout_b = {det.vout_ov, 2'b00, det.vout_uv, det.vout_range, 2'b00,
         vout_oth_l};
      iout_b = {det.iout_oc, det.iout_oc_uv, det.iout_warn, 5'b00000};
      input_b = {vin_ov_l, vin_ovw_l, vin_uvw_l, 5'b00000};
      therm_b = {ot_f_l, ot_w_l, 6'b000000};
      cml_b = {det.bad_cmd, det.bad_data, 1'b0, det.mem_fault, 2'b00,
         det.cml_other, det.mem_busy};
      sum_b = {1'b0, det.part_off, det.vout_ov, iout_oc_l, 1'b0,
         (det.ot_fault | det.ot_warn), cml_l, (vout_oth_l | word_oth_l)};
      word_w = {(|vout_b), (|iout_b), det.vin_fault, 1'b0, det.pgood_n,
         2'b00, word_oth_l, sum_b};
   end

   // read mux, answer one cycle after request
   always_comb begin
      d = q;
      d.valid = req.rd;
      d.unsup = 1'b0;
      if (req.rd) begin
         d.data = `WORD_RESET;
         case (req.cmd)
            `CMD_STATUS_BYTE: d.data = {`ZERO_BYTE, sum_b};
            `CMD_STATUS_WORD: d.data = word_w;
            `CMD_VOUT_STATUS: d.data = {`ZERO_BYTE, vout_b};
            `CMD_IOUT_STATUS: d.data = {`ZERO_BYTE, iout_b};
            `CMD_INPUT_STATUS: d.data = {`ZERO_BYTE, input_b};
            `CMD_THERM_STATUS: d.data = {`ZERO_BYTE, therm_b};
            `CMD_CML_STATUS: d.data = {`ZERO_BYTE, cml_b};
            default: d.unsup = 1'b1;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd_data = q.data;
   assign rd_valid = q.valid;
   assign rd_unsup = q.unsup;

   // checks
   property p_vout_live;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_VOUT_STATUS)
         |=> (rd_data[7] == $past(det.vout_ov))
         && (rd_data[4] == $past(det.vout_uv));
   endproperty
   a_vout_live: assert property (p_vout_live)
      else $error("live output voltage bits wrong");

   property p_vout_resv;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_VOUT_STATUS)
         |=> rd_data[15:8] == 8'h00 && rd_data[6:5] == 2'b00
         && rd_data[2:1] == 2'b00;
   endproperty
   a_vout_resv: assert property (p_vout_resv)
      else $error("output voltage reserved bits set");

   property p_range;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_VOUT_STATUS && det.vout_range)
         |=> rd_data[3];
   endproperty
   a_range: assert property (p_range)
      else $error("range attempt bit missing");

   property p_word_low;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_STATUS_WORD)
         |=> rd_data[10:9] == 2'b00 && rd_data[7:0] == $past(sum_b);
   endproperty
   a_word_low: assert property (p_word_low)
      else $error("status word low byte or reserved bits wrong");

   property p_word_other;
      @(posedge mclk) disable iff (!resetn)
      det.word_other ##1 (req.rd && req.cmd == `CMD_STATUS_WORD)
         |=> rd_data[8];
   endproperty
   a_word_other: assert property (p_word_other)
      else $error("unknown word bit not latched");

   property p_vout_other;
      @(posedge mclk) disable iff (!resetn)
      det.vout_other |=> vout_oth_l;
   endproperty
   a_vout_other: assert property (p_vout_other)
      else $error("unknown vout bit not latched");

   property p_pin_latch;
      @(posedge mclk) disable iff (!resetn)
      input_overvoltage_sense_pin [*3] |=> vin_ov_l;
   endproperty
   a_pin_latch: assert property (p_pin_latch)
      else $error("pin over-voltage not latched");

   property p_hold;
      @(posedge mclk) disable iff (!resetn)
      ot_f_l && !clear_faults |=> ot_f_l;
   endproperty
   a_hold: assert property (p_hold)
      else $error("latched flag dropped without clear");

   property p_input_resv;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_INPUT_STATUS)
         |=> rd_data[4:0] == 5'b00000
         && rd_data[6:5] == $past({vin_ovw_l, vin_uvw_l});
   endproperty
   a_input_resv: assert property (p_input_resv)
      else $error("input byte wrong");

   property p_therm;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_THERM_STATUS)
         |=> rd_data[5:0] == 6'h00 && rd_data[7] == $past(ot_f_l);
   endproperty
   a_therm: assert property (p_therm)
      else $error("temperature byte wrong");

   property p_cml;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_CML_STATUS)
         |=> rd_data[5] == 1'b0 && rd_data[3:2] == 2'b00
         && rd_data[0] == $past(det.mem_busy);
   endproperty
   a_cml: assert property (p_cml)
      else $error("comm byte wrong");

   property p_vout_uv;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_VOUT_STATUS)
         |=> rd_data[4] == $past(det.vout_uv);
   endproperty
   a_vout_uv: assert property (p_vout_uv)
      else $error("live under-voltage bit wrong");

   property p_range_live;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_VOUT_STATUS && !det.vout_range)
         |=> !rd_data[3];
   endproperty
   a_range_live: assert property (p_range_live)
      else $error("range attempt bit set without attempt");

   property p_vin_ovw;
      @(posedge mclk) disable iff (!resetn)
      det.vin_ov_warn |=> vin_ovw_l;
   endproperty
   a_vin_ovw: assert property (p_vin_ovw)
      else $error("input over-voltage warning not latched");

   property p_vin_uvw;
      @(posedge mclk) disable iff (!resetn)
      det.vin_uv_warn |=> vin_uvw_l;
   endproperty
   a_vin_uvw: assert property (p_vin_uvw)
      else $error("input under-voltage warning not latched");

   property p_ot_fault;
      @(posedge mclk) disable iff (!resetn)
      det.ot_fault |=> ot_f_l;
   endproperty
   a_ot_fault: assert property (p_ot_fault)
      else $error("over-temperature fault not latched");

   property p_ot_warn;
      @(posedge mclk) disable iff (!resetn)
      det.ot_warn |=> ot_w_l;
   endproperty
   a_ot_warn: assert property (p_ot_warn)
      else $error("over-temperature warning not latched");

   property p_clear;
      @(posedge mclk) disable iff (!resetn)
      clear_faults && !det.ot_fault |=> !ot_f_l;
   endproperty
   a_clear: assert property (p_clear)
      else $error("latched flag not cleared by clear command");

   property p_sum_byte;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_STATUS_BYTE)
         |=> rd_data[15:8] == 8'h00 && !rd_data[7] && !rd_data[3]
         && rd_data[4] == $past(iout_oc_l);
   endproperty
   a_sum_byte: assert property (p_sum_byte)
      else $error("summary byte wrong");

   property p_known;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd >= `CMD_STATUS_BYTE && req.cmd <= `CMD_CML_STATUS)
         |=> rd_valid && !rd_unsup;
   endproperty
   a_known: assert property (p_known)
      else $error("status read not answered");

   property p_unknown;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && (req.cmd < `CMD_STATUS_BYTE
         || req.cmd > `CMD_CML_STATUS))
         |=> rd_valid && rd_unsup && rd_data == 16'h0000;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown code answer wrong");

   property p_reset_zero;
      @(posedge mclk)
      $rose(resetn) |-> rd_data == 16'h0000 && !rd_valid && !rd_unsup;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("outputs not zero after reset");

   property p_therm_warn;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_THERM_STATUS)
         |=> rd_data[6] == $past(ot_w_l);
   endproperty
   a_therm_warn: assert property (p_therm_warn)
      else $error("temperature warning bit wrong");

   property p_input_pin;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_INPUT_STATUS)
         |=> rd_data[7] == $past(vin_ov_l);
   endproperty
   a_input_pin: assert property (p_input_pin)
      else $error("input pin over-voltage bit wrong");

   property p_cml_bits;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.cmd == `CMD_CML_STATUS)
         |=> rd_data[7:6] == $past({det.bad_cmd, det.bad_data})
         && rd_data[4] == $past(det.mem_fault)
         && rd_data[1] == $past(det.cml_other);
   endproperty
   a_cml_bits: assert property (p_cml_bits)
      else $error("comm byte fault bits wrong");

   property p_vout_oth_hold;
      @(posedge mclk) disable iff (!resetn)
      vout_oth_l && !clear_faults |=> vout_oth_l;
   endproperty
   a_vout_oth_hold: assert property (p_vout_oth_hold)
      else $error("unknown vout bit dropped without clear");

   property p_word_oth_hold;
      @(posedge mclk) disable iff (!resetn)
      word_oth_l && !clear_faults |=> word_oth_l;
   endproperty
   a_word_oth_hold: assert property (p_word_oth_hold)
      else $error("unknown word bit dropped without clear");

   c_word: cover property (@(posedge mclk) disable iff (!resetn)
      req.rd && req.cmd == `CMD_STATUS_WORD);
   c_clear: cover property (@(posedge mclk) disable iff (!resetn)
      ot_f_l ##1 !ot_f_l);
   c_unsup: cover property (@(posedge mclk) disable iff (!resetn)
      rd_unsup);
   c_vin_ov: cover property (@(posedge mclk) disable iff (!resetn)
      !vin_ov_l ##1 vin_ov_l);
   c_range: cover property (@(posedge mclk) disable iff (!resetn)
      req.rd && req.cmd == `CMD_VOUT_STATUS && det.vout_range);
endmodule // fault_status_bank

// [bench/status_host.sv]
// host model: issues one status read per go request, keeps the answer
// assumes the bank answers one mclk cycle after the strobe
`timescale 1ns/1ps
module status_host
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // bench command
   input wire logic go,
   input wire logic [7:0] code,
   // read request
   output read_req_s req,
   // answer from the bank
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_unsup,
   // captured answer
   output logic [15:0] got,
   output logic got_unsup,
   output logic done
);
   // strobe on the falling edge, idle code toggles
   always @(negedge mclk or negedge resetn) begin
      if (!resetn) begin
         req <= '0;
      end else begin
         req.rd <= go;
         req.cmd <= go ? code : ~req.cmd;
      end
   end
   // answer taken at the edge where rd_valid is high
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         got <= 16'h0000;
         got_unsup <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= rd_valid;
         if (rd_valid) begin
            got <= rd_data;
            got_unsup <= rd_unsup;
         end
      end
   end
endmodule // status_host

// [bench/tb.sv]
// bench for fault_status_bank: random detector levels, reads by host model
// assumes single mclk domain, detectors driven on the falling edge
`timescale 1ns/1ps
module tb
   import fault_status_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   detect_s det = '0;
   logic pin = 1'b0;
   logic clr = 1'b0;
   logic go = 1'b0;
   logic [7:0] code = 8'h00;
   read_req_s req;
   logic [15:0] rd_data, got;
   logic rd_valid, rd_unsup, done, got_unsup, p;
   detect_s d;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #25 mclk = ~mclk;
   fault_status_bank fault_status_bank_i (.mclk(mclk), .resetn(resetn),
      .det(det), .input_overvoltage_sense_pin(pin), .clear_faults(clr),
      .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_unsup(rd_unsup));
   status_host status_host_i (.mclk(mclk), .resetn(resetn), .go(go),
      .code(code), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_unsup(rd_unsup), .got(got), .got_unsup(got_unsup), .done(done));
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         give_verdict;
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // expected answer from live levels v, latched causes l, latched pin pl
   function automatic logic [15:0] expv(input logic [7:0] c,
      input detect_s v, input detect_s l, input logic pl);
      logic [7:0] vo, io, sb;
      vo = {v.vout_ov, 2'h0, v.vout_uv, v.vout_range, 2'h0, l.vout_other};
      io = {v.iout_oc, v.iout_oc_uv, v.iout_warn, 5'h00};
      sb = {1'b0, v.part_off, v.vout_ov, l.iout_oc, 1'b0,
         v.ot_fault | v.ot_warn,
         l.bad_cmd | l.bad_data | l.mem_fault | l.cml_other,
         l.word_other | l.vout_other};
      case (c)
         8'h78: expv = {8'h00, sb};
         8'h79: expv = {|vo, |io, v.vin_fault, 1'b0, v.pgood_n, 2'h0,
            l.word_other, sb};
         8'h7A: expv = {8'h00, vo};
         8'h7B: expv = {8'h00, io};
         8'h7C: expv = {8'h00, pl, l.vin_ov_warn, l.vin_uv_warn, 5'h00};
         8'h7D: expv = {8'h00, l.ot_fault, l.ot_warn, 6'h00};
         8'h7E: expv = {8'h00, v.bad_cmd, v.bad_data, 1'b0, v.mem_fault,
            2'h0, v.cml_other, v.mem_busy};
         default: expv = 16'h0000;
      endcase
   endfunction
   task rd(input logic [7:0] c);
      int k;
      @(negedge mclk);
      go <= 1'b1;
      code <= c;
      @(negedge mclk);
      go <= 1'b0;
      for (k = 0; k < 6 && done !== 1'b1; k++) @(negedge mclk);
      chk({15'h0000, done}, 16'h0001);
   endtask
   task rd_all(input detect_s v, input detect_s l, input logic pl,
      input logic no_cml);
      logic [7:0] c;
      for (c = 8'h78; c <= 8'h7E; c++) begin
         if (!(no_cml && c == 8'h7E)) begin
            rd(c);
            chk(got, expv(c, v, l, pl));
            chk({15'h0000, got_unsup}, 16'h0000);
         end
      end
   endtask
   task wait_n(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task pulse_clr;
      @(negedge mclk);
      clr <= 1'b1;
      @(negedge mclk);
      clr <= 1'b0;
   endtask
   initial begin
      logic [31:0] r;
      int i;
      r = $urandom(32'h5d731e3c);
      wait_n(6);
      resetn <= 1'b1;
      rd_all('0, '0, 1'b0, 1'b0);
      $display("test reset values done");
      for (i = 0; i < 5; i++) begin
         r = $urandom;
         rd(i == 0 ? 8'h77 : i == 1 ? 8'h7F : {1'b1, r[6:0]});
         chk(got, 16'h0000);
         chk({15'h0000, got_unsup}, 16'h0001);
      end
      $display("test unknown codes done");
      for (i = 0; i < 20; i++) begin
         r = $urandom;
         d = r[19:0];
         p = r[31];
         if (i == 0) begin
            d = '1;
            p = 1'b1;
         end
         det <= d;
         pin <= p;
         wait_n(4);
         pulse_clr;
         rd_all(d, d, p, 1'b0);
         det <= '0;
         pin <= 1'b0;
         wait_n(4);
         rd_all('0, d, p, 1'b1);
         pulse_clr;
         wait_n(1);
         rd_all('0, '0, 1'b0, 1'b0);
      end
      $display("test latch and clear done");
      give_verdict;
   end
endmodule // tb
